// file: src/sector_timing_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef SECTOR_TIMING_MAP_SVH
`define SECTOR_TIMING_MAP_SVH
`define OFS_DEC_CTRL 8'h00
`define OFS_GATE_DRIVE 8'h04
`define OFS_DEC_STATUS 8'h08
`define OFS_SECTOR_TIME 8'h0C
`define OFS_INDEX_TIME 8'h10
`define OFS_SEARCH_TIME 8'h14
`define OFS_POWER_ON_TIME 8'h18
`define OFS_PWM1_COMPARE 8'h1C
`define OFS_PIN_CONFIG 8'h20
`define OFS_FAULT_CFG 8'h24
`define OFS_COUNTER 8'h28
`define OFS_PULSE_BASE 8'h40
`define OFS_PULSE_LAST 8'h5C
// decoder control fields
`define CTL_FORCE_SEARCH_WINDOW 0
`define CTL_TIMER_EN 3
`define CTL_PIN_SEL_LO 4
`define CTL_WIDTH_LO 7
`define CTL_DIRECT_GATE 9
// decoder status fields
`define STA_MARK_FOUND 0
`define STA_SEARCH_WINDOW 1
`define STA_CLOSE_SEARCH_WINDOW 2
// pin config fields
`define PIN_PWM1_EN 0
`define PIN_PWM2_EN 1
// fault safety config fields
`define FLT_SERVO_SECTOR_SIGNAL_GATES 14
`define FLT_MISS_READ 13
`define FLT_PIN_DRIVE 12
`define FLT_NEG_QWG 11
`define FLT_NEG_WG 10
`define FLT_NO_XOR 9
`define FLT_NEG_AE 8
`define FLT_CFG_RESET 16'h00A0
`define FLT_CFG_WMASK 16'h7FFF
// pulse width is (code + 1) steps of this many clocks
`define PULSE_STEP 3'h4
`endif

// file: src/sector_timing_pkg.sv
// types shared by the sector timing unit
package sector_timing_pkg;
    typedef enum logic {PULSE_IDLE, PULSE_HIGH} pulse_state_type;
    typedef enum logic [2:0] {
        PIN_SEARCH_WINDOW, PIN_SERVO_SECTOR_SIGNAL, PIN_TMARK, PIN_SRST, PIN_DBG0, PIN_DBG1, PIN_DBG2, PIN_DBG3
    } pin_sel_type;
endpackage : sector_timing_pkg

// file: src/pulse_stretch.sv
// stretches a one-cycle trigger into a pulse of 4, 8, 12 or 16 clocks
`include "sector_timing_map.svh"
module pulse_stretch
    import sector_timing_pkg::*;
(
    input wire logic mclk, // clock
    input wire logic rstn, // sync reset, low
    input wire logic trigger, // one-cycle start
    input wire logic [1:0] widthCode, // width = 4*(code+1)
    output logic pulse // stretched pulse
);
    pulse_state_type state_r;
    logic [4:0] count_r;
    logic [4:0] lenNxt;

    assign lenNxt = ({3'h0, widthCode} + 5'h01) * {2'h0, `PULSE_STEP};

    // a retrigger during a pulse restarts the full width
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state_r <= PULSE_IDLE;
            count_r <= 5'h00;
            pulse <= 1'b0;
        end else begin
            case (state_r)
                PULSE_IDLE: begin
                    if (trigger) begin
                        state_r <= PULSE_HIGH;
                        // full length loaded: the pulse drops on the edge that sees a count of one
                        count_r <= lenNxt;
                        pulse <= 1'b1;
                    end
                end
                PULSE_HIGH: begin
                    if (trigger) begin
                        count_r <= lenNxt;
                    end else if (count_r == 5'h01) begin
                        state_r <= PULSE_IDLE;
                        count_r <= 5'h00;
                        pulse <= 1'b0;
                    end else begin
                        count_r <= count_r - 5'h01;
                    end
                end
                default: begin
                    state_r <= PULSE_IDLE;
                end
            endcase
        end
    end
endmodule : pulse_stretch

// file: src/servo_sector_timing_control.sv
// sector timing unit: counter, compares, pulses, pins and fault config
`include "sector_timing_map.svh"
module servo_sector_timing_control
    import sector_timing_pkg::*;
(
    input wire logic mclk, // decoder clock
    input wire logic rstn, // sync reset, low
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_we_i, // write
    input wire logic [7:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte lanes
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // acknowledge
    input wire logic timerClear, // sequencer counter clear
    input wire logic searchReset, // sequencer search reset
    input wire logic markDetected, // timing mark found
    input wire logic servoSector, // servo sector signal
    input wire logic [7:0] seqGates, // sequencer gate pins, bit 0 select A
    input wire logic [3:0] debugSignals, // extra signals for the search pin
    input wire logic writeGateIn, // write gate pin
    input wire logic aeErrorIn, // arm electronics error pin
    input wire logic driveFaultIn, // fault pin level
    input wire logic internalFault, // internal drive fault
    input wire logic missingMark, // missing mark latch
    output logic dataSectorPulse, // data sector pulse
    output logic indexPulse, // index pulse
    output logic searchWindow, // internal search window
    output logic searchPin, // search pin
    output logic powerUpStrobe, // power-up strobe
    output logic [1:0] pwmPins, // general pins 10:9 in pwm mode
    output logic [7:0] gateOut, // gate, discharge, select pins
    output logic qualWriteGate, // qualified write gate
    output logic aeErrorActive, // ae error, normalised
    output logic missFault, // missing mark drive fault
    output logic driveFaultOut, // fault pin drive level
    output logic driveFaultOe // fault pin enable
);
    logic [15:0] counter_r;
    logic [15:0] sectorTime_r;
    logic [15:0] decCtrl_r;
    logic [15:0] gateDrive_r;
    logic [15:0] indexTime_r;
    logic [15:0] searchTime_r;
    logic [15:0] powerOnTime_r;
    logic [15:0] pwm1Compare_r;
    logic [15:0] pinConfig_r;
    logic [15:0] faultCfg_r;
    logic [15:0] pulseTime_r [8];
    logic indexArmed_r;
    logic markFound_r;
    logic [1:0] pwm_r;
    logic wrNow;
    logic [15:0] wrData;
    logic [15:0] wrMask;
    logic [15:0] rdNxt;
    logic timerOn;
    logic [7:0] secHit;
    logic dsecTrig;
    logic indexTrig;
    logic srchHit;
    logic closeSrch;
    logic markReset;
    logic wgActive;
    logic wgBlocked;
    logic select_a_output;
    pin_sel_type pinSel;

    assign wrNow = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign wrMask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign timerOn = decCtrl_r[`CTL_TIMER_EN];
    assign pinSel = pin_sel_type'(decCtrl_r[`CTL_PIN_SEL_LO +: 3]);
    assign closeSrch = wrNow && wb_adr_i == `OFS_DEC_STATUS && wb_sel_i[0]
        && wb_dat_i[`STA_CLOSE_SEARCH_WINDOW];
    assign markReset = searchReset && markDetected;

    function automatic logic [15:0] merge(input logic [15:0] old);
        merge = (old & ~wrMask) | (wrData & wrMask);
    endfunction : merge
    assign wrData = wb_dat_i[15:0];

    // classic wishbone: ack one cycle after request, write lands on the ack edge
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o <= {16'h0000, rdNxt};
        end
    end

    always_comb begin
        rdNxt = 16'h0000;
        if (wb_adr_i == `OFS_DEC_CTRL) begin
            rdNxt = decCtrl_r;
        end else if (wb_adr_i == `OFS_GATE_DRIVE) begin
            rdNxt = gateDrive_r;
        end else if (wb_adr_i == `OFS_DEC_STATUS) begin
            rdNxt = {14'h0000, searchWindow, markFound_r};
        end else if (wb_adr_i == `OFS_SECTOR_TIME) begin
            rdNxt = sectorTime_r;
        end else if (wb_adr_i == `OFS_INDEX_TIME) begin
            rdNxt = indexTime_r;
        end else if (wb_adr_i == `OFS_SEARCH_TIME) begin
            rdNxt = searchTime_r;
        end else if (wb_adr_i == `OFS_POWER_ON_TIME) begin
            rdNxt = powerOnTime_r;
        end else if (wb_adr_i == `OFS_PWM1_COMPARE) begin
            rdNxt = pwm1Compare_r;
        end else if (wb_adr_i == `OFS_PIN_CONFIG) begin
            rdNxt = pinConfig_r;
        end else if (wb_adr_i == `OFS_FAULT_CFG) begin
            rdNxt = faultCfg_r;
        end else if (wb_adr_i == `OFS_COUNTER) begin
            rdNxt = counter_r;
        end else if (wb_adr_i >= `OFS_PULSE_BASE && wb_adr_i <= `OFS_PULSE_LAST
            && wb_adr_i[1:0] == 2'h0 && !timerOn) begin
            rdNxt = pulseTime_r[wb_adr_i[4:2]];
        end
    end

    // software-written configuration
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            decCtrl_r <= 16'h0000;
            gateDrive_r <= 16'h0000;
            indexTime_r <= 16'h0000;
            searchTime_r <= 16'hFFFF;
            powerOnTime_r <= 16'hFFFF;
            pwm1Compare_r <= 16'hFFFF;
            pinConfig_r <= 16'h0000;
            faultCfg_r <= `FLT_CFG_RESET;
        end else begin
            if (wrNow && wb_adr_i == `OFS_DEC_CTRL) begin
                decCtrl_r <= merge(decCtrl_r);
            end else if (markReset || closeSrch) begin
                decCtrl_r[`CTL_FORCE_SEARCH_WINDOW] <= 1'b0;
            end
            if (wrNow && wb_adr_i == `OFS_GATE_DRIVE) begin
                gateDrive_r <= merge(gateDrive_r);
            end
            if (wrNow && wb_adr_i == `OFS_INDEX_TIME) begin
                indexTime_r <= merge(indexTime_r);
            end
            if (wrNow && wb_adr_i == `OFS_SEARCH_TIME) begin
                searchTime_r <= merge(searchTime_r);
            end
            if (wrNow && wb_adr_i == `OFS_POWER_ON_TIME) begin
                powerOnTime_r <= merge(powerOnTime_r);
            end
            if (wrNow && wb_adr_i == `OFS_PWM1_COMPARE) begin
                pwm1Compare_r <= merge(pwm1Compare_r);
            end
            if (wrNow && wb_adr_i == `OFS_PIN_CONFIG) begin
                pinConfig_r <= merge(pinConfig_r);
            end
            if (wrNow && wb_adr_i == `OFS_FAULT_CFG) begin
                faultCfg_r <= merge(faultCfg_r) & `FLT_CFG_WMASK;
            end
        end
    end

    // pulse times reset to zero, i.e. disabled
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            for (int i = 0; i < 8; i++) begin
                pulseTime_r[i] <= 16'h0000;
            end
        end else if (wrNow && wb_adr_i >= `OFS_PULSE_BASE && wb_adr_i <= `OFS_PULSE_LAST
            && wb_adr_i[1:0] == 2'h0) begin
            pulseTime_r[wb_adr_i[4:2]] <= merge(pulseTime_r[wb_adr_i[4:2]]);
        end
    end

    // sector counter; a clear copies the count first
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            counter_r <= 16'h0000;
            sectorTime_r <= 16'h0000;
        end else if (timerClear) begin
            sectorTime_r <= counter_r;
            counter_r <= 16'h0000;
        end else if (timerOn) begin
            counter_r <= counter_r + 16'h0001;
        end
    end

    // zero disables a slot; no match during the clear cycle
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            secHit[i] = timerOn && !timerClear && pulseTime_r[i] != 16'h0000
                && counter_r == pulseTime_r[i];
        end
    end
    assign dsecTrig = |secHit;
    assign indexTrig = indexArmed_r && timerOn && !timerClear && counter_r == indexTime_r;
    assign srchHit = timerOn && !timerClear && counter_r == searchTime_r;

    pulse_stretch dsecStretch (
        .mclk(mclk),
        .rstn(rstn),
        .trigger(dsecTrig),
        .widthCode(decCtrl_r[`CTL_WIDTH_LO +: 2]),
        .pulse(dataSectorPulse)
    );

    pulse_stretch indexStretch (
        .mclk(mclk),
        .rstn(rstn),
        .trigger(indexTrig),
        .widthCode(decCtrl_r[`CTL_WIDTH_LO +: 2]),
        .pulse(indexPulse)
    );

    // rewrite rearms; a rewrite in the firing cycle wins
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            indexArmed_r <= 1'b0;
        end else if (wrNow && wb_adr_i == `OFS_INDEX_TIME) begin
            indexArmed_r <= 1'b1;
        end else if (indexTrig) begin
            indexArmed_r <= 1'b0;
        end
    end

    // search window and mark-found flag; setting wins over clearing, except that a close or mark reset ends a forced window
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            searchWindow <= 1'b0;
            markFound_r <= 1'b0;
        end else begin
            if (srchHit || (decCtrl_r[`CTL_FORCE_SEARCH_WINDOW] && !markReset && !closeSrch)) begin
                searchWindow <= 1'b1;
            end else if (searchReset || closeSrch) begin
                searchWindow <= 1'b0;
            end
            if (markReset) begin
                markFound_r <= 1'b1;
            end else if (wrNow && wb_adr_i == `OFS_DEC_STATUS && wb_sel_i[0]
                && wb_dat_i[`STA_MARK_FOUND]) begin
                markFound_r <= 1'b0;
            end
        end
    end

    // pin mux only picks what leaves the chip; searchWindow itself is untouched
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            searchPin <= 1'b0;
        end else begin
            case (pinSel)
                PIN_SEARCH_WINDOW: searchPin <= searchWindow;
                PIN_SERVO_SECTOR_SIGNAL: searchPin <= servoSector;
                PIN_TMARK: searchPin <= markDetected;
                PIN_SRST: searchPin <= searchReset;
                PIN_DBG0: searchPin <= debugSignals[0];
                PIN_DBG1: searchPin <= debugSignals[1];
                PIN_DBG2: searchPin <= debugSignals[2];
                default: searchPin <= debugSignals[3];
            endcase
        end
    end

    // strobe and pwm
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            powerUpStrobe <= 1'b0;
            pwm_r <= 2'h0;
            pwmPins <= 2'h0;
        end else begin
            powerUpStrobe <= timerOn && !timerClear && !pinConfig_r[`PIN_PWM2_EN]
                && counter_r == powerOnTime_r;
            if (timerClear) begin
                pwm_r <= 2'h3;
            end else begin
                if (counter_r == pwm1Compare_r) begin
                    pwm_r[0] <= 1'b0;
                end
                if (counter_r == powerOnTime_r) begin
                    pwm_r[1] <= 1'b0;
                end
            end
            pwmPins <= pwm_r & pinConfig_r[`PIN_PWM2_EN:`PIN_PWM1_EN];
        end
    end

    // write gate and fault safety
    assign wgActive = writeGateIn ^ faultCfg_r[`FLT_NEG_WG];
    assign wgBlocked = faultCfg_r[`FLT_SERVO_SECTOR_SIGNAL_GATES] && servoSector;
    assign select_a_output = seqGates[0] || (!faultCfg_r[`FLT_PIN_DRIVE] && driveFaultIn);

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            qualWriteGate <= 1'b0;
            aeErrorActive <= 1'b0;
            missFault <= 1'b0;
            driveFaultOut <= 1'b0;
            driveFaultOe <= 1'b0;
            gateOut <= 8'h00;
        end else begin
            qualWriteGate <= (wgActive && !wgBlocked) ^ faultCfg_r[`FLT_NEG_QWG];
            aeErrorActive <= faultCfg_r[`FLT_NO_XOR] ? aeErrorIn
                : aeErrorIn ^ faultCfg_r[`FLT_NEG_AE];
            missFault <= missingMark && (wgActive || faultCfg_r[`FLT_MISS_READ]);
            driveFaultOe <= faultCfg_r[`FLT_PIN_DRIVE];
            driveFaultOut <= faultCfg_r[`FLT_PIN_DRIVE] && internalFault;
            if (decCtrl_r[`CTL_DIRECT_GATE]) begin
                gateOut <= gateDrive_r[7:0];
            end else begin
                gateOut <= {seqGates[7:1], select_a_output};
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    property p_capture;
        timerClear |=> sectorTime_r == $past(counter_r) && counter_r == 16'h0000;
    endproperty
    a_capture: assert property (p_capture) else $error("sector time not captured");

    property p_count;
        !timerClear && timerOn |=> counter_r == $past(counter_r) + 16'h0001;
    endproperty
    a_count: assert property (p_count) else $error("counter did not step");

    property p_data_sector_pulse;
        dsecTrig |=> dataSectorPulse [*4];
    endproperty
    a_data_sector_pulse: assert property (p_data_sector_pulse) else $error("data sector pulse too short");

    property p_index_once;
        indexTrig |=> !indexArmed_r || $past(wrNow && wb_adr_i == `OFS_INDEX_TIME);
    endproperty
    a_index_once: assert property (p_index_once) else $error("index rearmed");

    property p_width;
        indexTrig && decCtrl_r[8:7] == 2'h0 ##1 !indexTrig [*4]
            |-> indexPulse ##1 !indexPulse;
    endproperty
    a_width: assert property (p_width) else $error("index width not 4");

    property p_search_window;
        srchHit |=> searchWindow;
    endproperty
    a_search_window: assert property (p_search_window) else $error("search window not opened");

    property p_mark;
        markReset |=> markFound_r && !decCtrl_r[`CTL_FORCE_SEARCH_WINDOW];
    endproperty
    a_mark: assert property (p_mark) else $error("mark reset not handled");

    property p_close;
        closeSrch && !srchHit |=> !searchWindow;
    endproperty
    a_close: assert property (p_close) else $error("search window not closed");

    property p_pwm;
        timerClear && pinConfig_r[0] && !wrNow |=> ##1 pwmPins[0];
    endproperty
    a_pwm: assert property (p_pwm) else $error("pwm pin not high");

    property p_strobe;
        pinConfig_r[`PIN_PWM2_EN] |=> !powerUpStrobe;
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe with pwm2");

    property p_ack;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack held");

    c_data_sector_pulse: cover property (dsecTrig ##1 dataSectorPulse);
    c_index: cover property (indexTrig);
    c_mark: cover property (markReset ##1 markFound_r);
    c_wrap: cover property (counter_r == 16'hFFFF ##1 counter_r == 16'h0000);
endmodule : servo_sector_timing_control

// file: tb/seq_model.sv
// behavioural burst and timing mark sequencer driving the sector timing unit
module seq_model (
    input wire logic mclk, // clock
    input wire logic rstn, // sync reset, low
    input wire logic frameReq, // start a servo frame
    input wire logic markReq, // report a found mark
    output logic timerClear, // counter clear command
    output logic searchReset, // search reset command
    output logic markDetected, // timing mark found
    output logic servoSector // servo sector level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] sectorCnt_r;
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            timerClear <= 1'b0;
            searchReset <= 1'b0;
            markDetected <= 1'b0;
            sectorCnt_r <= 4'h0;
        end else begin
            // one clear per frame, issued the cycle after frameReq
            timerClear <= frameReq;
            // search reset comes together with the found mark
            searchReset <= markReq;
            markDetected <= markReq;
            if (frameReq) begin
                sectorCnt_r <= 4'hF;
            end else if (sectorCnt_r != 4'h0) begin
                sectorCnt_r <= sectorCnt_r - 4'h1;
            end
        end
    end
    assign servoSector = (sectorCnt_r != 4'h0);
endmodule : seq_model

// file: tb/testbench.sv
// self-checking bench for the sector timing unit
`include "sector_timing_map.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int GAP = 40;
    logic mclk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, isRead = 0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, expQ[$], seed = 32'h2D4E7450;
    logic ack, frameReq = 0, markReq = 0, flt = 0;
    logic tClr, sRst, mDet, servo_sector_signal, data_sector_pulse, idx, search_window, srchPin, pus, dfo, dfoe;
    logic [1:0] pwm;
    logic [15:0] p0, ctrlVal;
    logic [7:0] gates = 8'h00, gout, gdrv;
    logic wg = 0, ae = 0, mm = 0, qwg, aea, mf;
    int bad_count = 0, total_checks = 0, nDsec, nIdx, nPus, w;
    always #2 mclk = ~mclk;
    seq_model seqm (.mclk(mclk), .rstn(rstn), .frameReq(frameReq), .markReq(markReq),
        .timerClear(tClr), .searchReset(sRst), .markDetected(mDet), .servoSector(servo_sector_signal));
    servo_sector_timing_control uut (.mclk(mclk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .timerClear(tClr), .searchReset(sRst), .markDetected(mDet),
        .servoSector(servo_sector_signal), .seqGates(gates), .debugSignals(4'h0), .writeGateIn(wg),
        .aeErrorIn(ae), .driveFaultIn(flt), .internalFault(flt), .missingMark(mm),
        .dataSectorPulse(data_sector_pulse), .indexPulse(idx), .searchWindow(search_window), .searchPin(srchPin),
        .powerUpStrobe(pus), .pwmPins(pwm), .gateOut(gout), .qualWriteGate(qwg),
        .aeErrorActive(aea), .missFault(mf), .driveFaultOut(dfo), .driveFaultOe(dfoe));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, e, s);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr;
        adr <= a;
        wdat <= d;
        isRead <= !wr;
        do @(posedge mclk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        isRead <= 1'b0;
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expQ.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd
    // read data is judged where the answer appears, not in the requesting task
    always @(posedge mclk) begin
        if (ack === 1'b1 && isRead === 1'b1) check("read data", expQ.pop_front(), rdat);
    end
    task automatic frames(input int n, input logic [1:0] en);
        nDsec = 0;
        nIdx = 0;
        nPus = 0;
        repeat (n) begin
            @(posedge mclk);
            frameReq <= 1'b1;
            @(posedge mclk);
            frameReq <= 1'b0;
            for (int j = 0; j < GAP - 2; j++) begin
                @(posedge mclk);
                #1;
                nDsec += int'(data_sector_pulse === 1'b1);
                nIdx += int'(idx === 1'b1);
                nPus += int'(pus === 1'b1);
                if (j == 6) check("pwm high", {30'h0, en}, {30'h0, pwm});
            end
            check("pwm low", 32'h0, {30'h0, pwm});
        end
    endtask : frames
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict
    initial begin
        #100000;
        bad_count++;
        $display("watchdog expired");
        give_verdict();
    end
    initial begin
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        seed = lfsr(seed);
        // lowest value kept above the counts reached before the first clear
        p0 = 16'h0004 + {12'h0, seed[3:0]};
        seed = lfsr(seed);
        ctrlVal = 16'h0008 | {7'h00, seed[1:0], 7'h00};
        w = 4 * (int'(ctrlVal[8:7]) + 1);
        flt <= seed[2];
        seed = lfsr(seed);
        gates <= seed[7:0];
        wg <= seed[8];
        ae <= seed[9];
        mm <= seed[10];
        gdrv = seed[23:16];
        rd(`OFS_FAULT_CFG, 32'h00A0);
        rd(`OFS_SEARCH_TIME, 32'hFFFF);
        rd(8'h3C, 32'h0);
        check("gates", {24'h0, gates[7:1], gates[0] | flt}, {24'h0, gout});
        check("qual write gate", {31'h0, wg}, {31'h0, qwg});
        check("ae error", {31'h0, ae}, {31'h0, aea});
        check("miss fault", {31'h0, mm & wg}, {31'h0, mf});
        bus(1'b1, `OFS_FAULT_CFG, 32'hFFFF);
        rd(`OFS_FAULT_CFG, 32'h7FFF);
        check("fault oe", 32'h1, {31'h0, dfoe});
        check("fault level", {31'h0, flt}, {31'h0, dfo});
        check("miss fault read", {31'h0, mm}, {31'h0, mf});
        check("ae no xor", {31'h0, ae}, {31'h0, aea});
        check("select a", {31'h0, gates[0]}, {31'h0, gout[0]});
        bus(1'b1, `OFS_FAULT_CFG, 32'h0500);
        rd(`OFS_FAULT_CFG, 32'h0500);
        check("qual wg low in", {31'h0, ~wg}, {31'h0, qwg});
        check("ae low", {31'h0, ~ae}, {31'h0, aea});
        $display("register test done");
        bus(1'b1, `OFS_PULSE_BASE, {16'h0, p0});
        rd(`OFS_PULSE_BASE, {16'h0, p0});
        bus(1'b1, `OFS_PULSE_BASE + 8'h04, 32'hFFFF);
        bus(1'b1, `OFS_INDEX_TIME, 32'h8);
        bus(1'b1, `OFS_SEARCH_TIME, 32'h1E);
        bus(1'b1, `OFS_POWER_ON_TIME, 32'hC);
        bus(1'b1, `OFS_PWM1_COMPARE, 32'h14);
        bus(1'b1, `OFS_PIN_CONFIG, 32'h1);
        bus(1'b1, `OFS_DEC_CTRL, {16'h0, ctrlVal});
        frames(2, 2'h1);
        check("data_sector_pulse cycles", 32'(2 * w), 32'(nDsec));
        check("index cycles", 32'(w), 32'(nIdx));
        check("strobe cycles", 32'h2, 32'(nPus));
        check("window", 32'h1, {31'h0, search_window});
        check("search pin", 32'h1, {31'h0, srchPin});
        rd(`OFS_SECTOR_TIME, 32'(GAP - 1));
        rd(`OFS_PULSE_BASE, 32'h0);
        $display("frame test done");
        bus(1'b1, `OFS_DEC_STATUS, 32'h4);
        repeat (2) @(posedge mclk);
        #1;
        check("window closed", 32'h0, {31'h0, search_window});
        bus(1'b1, `OFS_DEC_CTRL, {16'h0, ctrlVal | 16'h0001});
        repeat (2) @(posedge mclk);
        #1;
        check("window forced", 32'h1, {31'h0, search_window});
        @(posedge mclk);
        markReq <= 1'b1;
        @(posedge mclk);
        markReq <= 1'b0;
        repeat (3) @(posedge mclk);
        rd(`OFS_DEC_CTRL, {16'h0, ctrlVal});
        rd(`OFS_DEC_STATUS, 32'h1);
        $display("search test done");
        bus(1'b1, `OFS_GATE_DRIVE, {24'h0, gdrv});
        bus(1'b1, `OFS_DEC_CTRL, {16'h0, ctrlVal | 16'h0200});
        rd(`OFS_GATE_DRIVE, {24'h0, gdrv});
        check("direct gates", {24'h0, gdrv}, {24'h0, gout});
        bus(1'b1, `OFS_PIN_CONFIG, 32'h3);
        frames(1, 2'h3);
        check("strobe with pwm2", 32'h0, 32'(nPus));
        check("index not rearmed", 32'h0, 32'(nIdx));
        $display("pwm test done");
        give_verdict();
    end
endmodule : testbench
